// ### src/tsc_map.vh
// Mode codes, widths and clock selects of the timer/shifter combinations.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

`define TSC_T2_W          12
`define TSC_T2_NARROW_W   8
`define TSC_PRE_W         4
`define TSC_T3_W          8
`define TSC_SR_W          8

`define TSC_T2_WIDE       1'b0
`define TSC_T2_PRESCALED  1'b1

`define TSC_T2O_TOGGLE_A  3'h1
`define TSC_T2O_PRESCALE  3'h3
`define TSC_T2O_TOGGLE_B  3'h6

`define TSC_T3_MEASURE    4'h3
`define TSC_T3_BURST_T2   4'h6
`define TSC_T3_BURST_SR   4'h7
`define TSC_T3_FSK        4'h8

`define TSC_SR_MODE_SHIFT 2'h1

`define TSC_SH_TIMER2_MATCH_TOGGLE       2'h0
`define TSC_SH_PRESCALE   2'h1
`define TSC_SH_EXT        2'h2

`define TSC_CLK_INTERNAL  1'b0
`define TSC_CLK_EXTERNAL  1'b1

`endif

// ### src/tsc_timer2.v
// Timer 2: 12-bit compare counter or 8-bit counter behind 4-bit prescaler.
// Assumes a one-cycle count tick on the same clock as the block.
`include "tsc_map.vh"
module tsc_timer2 (
  input  wire                       ref_clk,
  input  wire                       sys_rst,
  input  wire                       tick,
  input  wire                       narrow,
  input  wire [`TSC_T2_W-1:0]       compare,
  input  wire [`TSC_PRE_W-1:0]      prescale,
  output reg                        match,
  output reg                        prescaler_match_pulse,
  output reg                        timer2_output_flop
);
  reg  [`TSC_T2_W-1:0]  count;
  reg  [`TSC_PRE_W-1:0] pre;
  wire                  pre_hit;
  wire                  step;
  wire                  hit;

  assign pre_hit = tick && (pre == prescale);
  assign step    = narrow ? pre_hit : tick;
  // Narrow mode compares only the low byte
  assign hit     = step && (narrow ?
                   (count[`TSC_T2_NARROW_W-1:0] ==
                    compare[`TSC_T2_NARROW_W-1:0]) :
                   (count == compare));

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      count                 <= {`TSC_T2_W{1'b0}};
      pre                   <= {`TSC_PRE_W{1'b0}};
      match                 <= 1'b0;
      prescaler_match_pulse <= 1'b0;
      timer2_output_flop    <= 1'b0;
    end
    else
    begin
      if (pre_hit)
        pre <= {`TSC_PRE_W{1'b0}};
      else if (tick)
        pre <= pre + 1'b1;
      prescaler_match_pulse <= narrow && pre_hit;
      if (hit)
        count <= {`TSC_T2_W{1'b0}};
      else if (step)
        count <= count + 1'b1;
      match <= hit;
      if (hit)
        timer2_output_flop <= ~timer2_output_flop;
    end
  end
endmodule

// ### src/tsc_shifter.v
// Serial shifter: 8-bit shift register, MSB first data output.
// Assumes load and shift strobes are one-cycle pulses on the same clock.
`include "tsc_map.vh"
module tsc_shifter (
  input  wire                  ref_clk,
  input  wire                  sys_rst,
  input  wire [1:0]            serial_mode,
  input  wire                  load,
  input  wire [`TSC_SR_W-1:0]  load_data,
  input  wire                  shift,
  output reg  [`TSC_SR_W-1:0]  shift_data,
  output reg                   data_out
);
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      shift_data <= {`TSC_SR_W{1'b0}};
      data_out   <= 1'b0;
    end
    else if (load)
    begin
      // Load wins over a coincident shift
      shift_data <= load_data;
      data_out   <= load_data[`TSC_SR_W-1];
    end
    else if (shift && serial_mode == `TSC_SR_MODE_SHIFT)
    begin
      shift_data <= {shift_data[`TSC_SR_W-2:0], 1'b0};
      data_out   <= shift_data[`TSC_SR_W-2];
    end
  end
endmodule

// ### src/tsc_top.v
// Combination logic of Timer 2, Timer 3 and the serial shifter.
// Assumes config ports are static while used; input pin is asynchronous.
`include "tsc_map.vh"

// Functional notes
// - Timer 2 runs 12-bit or prescaled 8-bit
// - Output modes 1/6 route match toggle onward
// - Mode 3 clocks Timer 3 from pin
// - Timer 2 toggle event resets Timer 3 in mode 3
// - Reset copies prior count into capture
// - Trigger also re-arms single-action compares
// - Mode 6 burst gated by Timer 2 flop
// - Timer 2 flop set enables output pin
// - Carrier toggles Timer 3 flop on matches
// - Timer 2 clock from Timer 3 toggle or other
// - Timer 3 takes internal or external clock
// - Serial mode 1 shifts 8 bits out
// - Mode 7 burst gated by shifter data
// - Timer 2 toggle can clock the shifter
// - Mode 8 data low compare1, high compare2
// - FSK toggles flop at two compare intervals
// - FSK shifter clocked by prescaler match pulse
// - FSK Timer 2 mode 3 is prescaled 8-bit
module tsc_top (
  input  wire                  ref_clk,
  input  wire                  sys_rst,
  input  wire                  timer3_input_pin,
  input  wire                  t2_narrow,
  input  wire [2:0]            t2_out_mode,
  input  wire [`TSC_T2_W-1:0]  t2_compare,
  input  wire [`TSC_PRE_W-1:0] t2_prescale,
  input  wire                  t2_clk_sel,
  input  wire                  t2_int_tick,
  input  wire [3:0]            t3_mode,
  input  wire                  t3_clk_sel,
  input  wire                  t3_int_tick,
  input  wire [`TSC_T3_W-1:0]  t3_compare1,
  input  wire [`TSC_T3_W-1:0]  t3_compare2,
  input  wire                  t3_cmp1_toggle,
  input  wire                  t3_cmp2_toggle,
  input  wire                  t3_cmp1_single,
  input  wire                  t3_cmp2_single,
  input  wire                  t3_rearm,
  input  wire [1:0]            serial_mode,
  input  wire [1:0]            shift_src,
  input  wire                  shift_ext_tick,
  input  wire                  shifter_load,
  input  wire [`TSC_SR_W-1:0]  shifter_load_data,
  output reg                   timer3_output_pin,
  output reg  [`TSC_T3_W-1:0]  t3_count,
  output reg  [`TSC_T3_W-1:0]  t3_capture,
  output reg                   t3_capture_strobe,
  output reg                   timer3_output_flop,
  output reg                   timer3_match_toggle,
  output reg                   timer2_match_toggle,
  output reg                   t2_flop_state,
  output reg                   shifter_data_out
);
  // Pin synchroniser; only the second stage feeds the edge detector
  reg                  pin_meta;
  reg                  pin_sync;
  reg                  pin_prev;
  wire                 pin_rise;

  // Timer 2 and shifter
  wire                 t2_tick;
  wire                 t2_narrow_eff;
  wire                 t2_match;
  wire                 t2_pre_pulse;
  wire                 t2_flop;
  wire                 t2_toggle_mode;
  wire                 timer2_match_toggle_event;
  reg                  sh_tick;
  wire [`TSC_SR_W-1:0] sh_data;
  wire                 sh_out;

  // Timer 3
  wire                 measure;
  wire                 fsk;
  reg                  t3_tick;
  reg                  arm1;
  reg                  arm2;
  wire                 hit1;
  wire                 hit2;
  wire                 fsk_hit;
  wire                 restart;
  reg  [`TSC_T3_W-1:0] next_count;
  reg                  next_flop;
  reg                  next_pin;
  reg                  next_timer3_match_toggle;
  reg                  gate;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= timer3_input_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev;

  // Timer 2 clock: Timer 3 toggle event or the internal source
  assign t2_tick = (t2_clk_sel == `TSC_CLK_EXTERNAL) ?
                   timer3_match_toggle : t2_int_tick;

  // Output mode 3 forces the prescaled 8-bit counter
  assign t2_narrow_eff = (t2_narrow == `TSC_T2_PRESCALED) ||
                         (t2_out_mode == `TSC_T2O_PRESCALE);

  tsc_timer2 u_timer2 (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .tick                  (t2_tick),
    .narrow                (t2_narrow_eff),
    .compare               (t2_compare),
    .prescale              (t2_prescale),
    .match                 (t2_match),
    .prescaler_match_pulse (t2_pre_pulse),
    .timer2_output_flop    (t2_flop)
  );

  assign t2_toggle_mode = (t2_out_mode == `TSC_T2O_TOGGLE_A) ||
                          (t2_out_mode == `TSC_T2O_TOGGLE_B);
  assign timer2_match_toggle_event     = t2_toggle_mode && t2_match;

  // Shift clock selection
  always @*
  begin
    case (shift_src)
      `TSC_SH_TIMER2_MATCH_TOGGLE:     sh_tick = timer2_match_toggle_event;
      `TSC_SH_PRESCALE: sh_tick = t2_pre_pulse;
      `TSC_SH_EXT:      sh_tick = shift_ext_tick;
      default:          sh_tick = 1'b0;
    endcase
  end

  tsc_shifter u_shifter (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .serial_mode (serial_mode),
    .load        (shifter_load),
    .load_data   (shifter_load_data),
    .shift       (sh_tick),
    .shift_data  (sh_data),
    .data_out    (sh_out)
  );

  assign measure = (t3_mode == `TSC_T3_MEASURE);
  assign fsk     = (t3_mode == `TSC_T3_FSK);

  // Timer 3 count source
  always @*
  begin
    if (measure)
      t3_tick = pin_rise;
    else if (t3_clk_sel == `TSC_CLK_EXTERNAL)
      t3_tick = pin_rise;
    else
      t3_tick = t3_int_tick;
  end

  // A match counts when the counter steps onto the compare value
  assign hit1 = t3_tick && arm1 &&
                (t3_count + 1'b1 == t3_compare1);
  assign hit2 = t3_tick && arm2 &&
                (t3_count + 1'b1 == t3_compare2);

  // FSK: shifter data picks the interval compare register
  assign fsk_hit = t3_tick && (sh_out ?
                   (t3_count + 1'b1 == t3_compare2) :
                   (t3_count + 1'b1 == t3_compare1));

  // Trigger restart from Timer 2 only in the measurement mode
  assign restart = measure && timer2_match_toggle_event;

  // Burst gate: Timer 2 flop in mode 6, shifter data in mode 7
  always @*
  begin
    case (t3_mode)
      `TSC_T3_BURST_T2: gate = t2_flop;
      `TSC_T3_BURST_SR: gate = sh_out;
      default:          gate = 1'b1;
    endcase
  end

  always @*
  begin
    next_count = t3_count;
    next_flop  = timer3_output_flop;
    next_timer3_match_toggle  = 1'b0;
    if (restart)
      next_count = {`TSC_T3_W{1'b0}};
    else if (fsk)
    begin
      if (fsk_hit)
      begin
        next_count = {`TSC_T3_W{1'b0}};
        next_flop  = ~timer3_output_flop;
        next_timer3_match_toggle  = 1'b1;
      end
      else if (t3_tick)
        next_count = t3_count + 1'b1;
    end
    else
    begin
      if (hit2)
        next_count = {`TSC_T3_W{1'b0}};
      else if (t3_tick)
        next_count = t3_count + 1'b1;
      if ((hit1 && t3_cmp1_toggle) ^ (hit2 && t3_cmp2_toggle))
        next_flop = ~timer3_output_flop;
      next_timer3_match_toggle = hit1 || hit2;
    end
    next_pin = next_flop && gate;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      t3_count            <= {`TSC_T3_W{1'b0}};
      t3_capture          <= {`TSC_T3_W{1'b0}};
      t3_capture_strobe   <= 1'b0;
      timer3_output_flop  <= 1'b0;
      timer3_output_pin   <= 1'b0;
      timer3_match_toggle <= 1'b0;
      timer2_match_toggle <= 1'b0;
      t2_flop_state       <= 1'b0;
      shifter_data_out    <= 1'b0;
      arm1                <= 1'b1;
      arm2                <= 1'b1;
    end
    else
    begin
      t3_count            <= next_count;
      timer3_output_flop  <= next_flop;
      timer3_output_pin   <= next_pin;
      timer3_match_toggle <= next_timer3_match_toggle;
      timer2_match_toggle <= timer2_match_toggle_event;
      t2_flop_state       <= t2_flop;
      shifter_data_out    <= sh_out;
      t3_capture_strobe   <= restart;
      // Edge arriving with the trigger belongs to the closing interval
      if (restart)
        t3_capture <= t3_tick ? t3_count + 1'b1 : t3_count;
      // Trigger or t3_rearm re-arms both compares; otherwise a single-action hit disarms its compare
      if (restart || t3_rearm)
      begin
        arm1 <= 1'b1;
        arm2 <= 1'b1;
      end
      else
      begin
        if (hit1 && t3_cmp1_single)
          arm1 <= 1'b0;
        if (hit2 && t3_cmp2_single)
          arm2 <= 1'b0;
      end
    end
  end
endmodule

// ### verification/tsc_checker.sv
// Port checker of the timer/shifter combinations, bound to tsc_top.
// Assumes config ports change only while sys_rst is held.
`include "tsc_map.vh"
module tsc_checker (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       timer3_input_pin,
  input wire logic [2:0] t2_out_mode,
  input wire logic [3:0] t3_mode,
  input wire logic [7:0] t3_compare1,
  input wire logic       t3_cmp1_toggle,
  input wire logic       t3_cmp2_toggle,
  input wire logic       timer3_output_pin,
  input wire logic [7:0] t3_count,
  input wire logic [7:0] t3_capture,
  input wire logic       t3_capture_strobe,
  input wire logic       timer3_output_flop,
  input wire logic       timer3_match_toggle,
  input wire logic       timer2_match_toggle,
  input wire logic       t2_flop_state,
  input wire logic       shifter_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_cap_prior_count: assert property (t3_capture_strobe |->
    t3_capture == $past(t3_count) ||
    t3_capture == $past(t3_count) + 8'h01) else $error("capture wrong");
  // Strobe trails the clearing edge, so the count seen now is the cleared one
  a_restart_clears: assert property (t3_capture_strobe &&
    t3_mode == `TSC_T3_MEASURE |-> t3_count == 8'h00)
    else $error("restart did not clear count");
  a_timer3_match_toggle_fsk: assert property (t3_mode == `TSC_T3_FSK |->
    timer3_match_toggle == $changed(timer3_output_flop))
    else $error("fsk match pulse off toggle");
  a_timer2_match_toggle_out_mode: assert property (timer2_match_toggle |->
    t2_out_mode == `TSC_T2O_TOGGLE_A || t2_out_mode == `TSC_T2O_TOGGLE_B)
    else $error("toggle in wrong output mode");
  // Two-stage sync plus edge detect, so the cause is 2..4 cycles back
  a_pin_counts: assert property (t3_mode == `TSC_T3_MEASURE &&
    t3_count == $past(t3_count) + 8'h01 |-> $past(timer3_input_pin, 2) ||
    $past(timer3_input_pin, 3) || $past(timer3_input_pin, 4))
    else $error("count step without pin edge");
  a_t2_gate: assert property (t3_mode == `TSC_T3_BURST_T2 &&
    $past(timer3_output_pin) |-> $past(timer3_output_flop) &&
    (t2_flop_state || $past(t2_flop_state))) else $error("burst gate off");
  a_so_gate: assert property (t3_mode == `TSC_T3_BURST_SR &&
    $past(timer3_output_pin) |-> $past(timer3_output_flop) &&
    (shifter_data_out || $past(shifter_data_out))) else $error("so gate off");
  a_carrier_match: assert property ($changed(timer3_output_flop) &&
    t3_mode != `TSC_T3_FSK |-> (t3_count == t3_compare1 && t3_cmp1_toggle)
    || (t3_count == 8'h00 && t3_cmp2_toggle)) else $error("stray toggle");
  a_fsk_wrap: assert property ($changed(timer3_output_flop) &&
    t3_mode == `TSC_T3_FSK |-> t3_count == 8'h00)
    else $error("fsk toggle off wrap");
  c_strobe: cover property (t3_capture_strobe);
  c_burst: cover property (t3_mode == `TSC_T3_BURST_T2 && timer3_output_pin);
  c_fsk: cover property (t3_mode == `TSC_T3_FSK && $changed(timer3_output_flop));
endmodule
bind tsc_top tsc_checker chk (.*);

// ### verification/tsc_pin_model.sv
// Behavioural source driving the external count pin.
// Assumes per is at least 4; the pin rests low while disabled.
module tsc_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       en,
  input  wire logic [3:0] per,
  output logic            pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] n = 4'h0;
  initial pin = 1'b0;
  // Two-cycle highs, so the synchroniser cannot miss one
  always @(posedge ref_clk)
  begin
    n <= (n + 4'h1 >= per) ? 4'h0 : n + 4'h1;
    pin <= en && (n < 4'h2);
  end
endmodule

// ### verification/tb.sv
// Self-checking bench of tsc_top with the pin model and checker.
// Assumes the design answers within the bounded waits below.
`include "tsc_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, sys_rst = 1, t2_narrow = 0, t2_clk_sel = 0;
  logic        t2_int_tick = 0, t3_clk_sel = 0, t3_int_tick = 0, pin_en = 0;
  logic        t3_cmp1_toggle = 0, t3_cmp2_toggle = 0, t3_cmp1_single = 0;
  logic        t3_cmp2_single = 0, shift_ext_tick = 0, shifter_load = 0;
  logic        t3_rearm = 0, fl, sd, chg;
  logic [2:0]  t2_out_mode = 0;
  logic [11:0] t2_compare = 0;
  logic [3:0]  t2_prescale = 0, t3_mode = 0, per = 4'h4;
  logic [7:0]  t3_compare1 = 0, t3_compare2 = 0, shifter_load_data = 0, d;
  logic [1:0]  serial_mode = 0, shift_src = 0;
  wire         timer3_input_pin, timer3_output_pin, t3_capture_strobe;
  wire         timer3_output_flop, timer3_match_toggle, timer2_match_toggle;
  wire         t2_flop_state, shifter_data_out;
  wire  [7:0]  t3_count, t3_capture;
  int          n_fail = 0, cmp_count = 0, seed = 32'h1aaa, c, f, hi, gt;
  tsc_top DUT (.*);
  tsc_pin_model pm (.ref_clk(ref_clk), .en(pin_en), .per(per),
    .pin(timer3_input_pin));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rst;
    sys_rst <= 1;
    cyc(3);
    sys_rst <= 0;
  endtask
  // Cycles and flop toggles from one strobe to the next
  task automatic meas;
    @(negedge ref_clk);
    c = 0;
    f = 0;
    fl = timer3_output_flop;
    do
    begin
      @(negedge ref_clk);
      c++;
      f += (timer3_output_flop !== fl);
      fl = timer3_output_flop;
    end
    while (t3_capture_strobe !== 1'b1 && c < 3000);
    @(posedge ref_clk);
  endtask
  task automatic ev(int s);
    c = 0;
    if (s)
    begin
      @(posedge ref_clk);
      shift_ext_tick <= 1;
      cyc(1);
      shift_ext_tick <= 0;
    end
    else
      do
        @(negedge ref_clk);
      while (timer2_match_toggle !== 1'b1 && c++ < 500);
    cyc(4);
    @(negedge ref_clk);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    complete_run;
  end
  initial
  begin
    cyc(12);
    t3_mode <= `TSC_T3_MEASURE;
    {pin_en, t2_int_tick, t3_cmp1_toggle, t3_cmp1_single} <= 4'hf;
    {t3_cmp2_single, t3_compare1, t3_compare2} <= 17'h1_02ff;
    for (int k = 0; k < 4; k++)
    begin
      per <= 4 + ($random(seed) & 7);
      t2_narrow <= k[0];
      t2_out_mode <= k[1] ? `TSC_T2O_TOGGLE_B : `TSC_T2O_TOGGLE_A;
      t2_compare <= 12'h03c + ($random(seed) & 63);
      t2_prescale <= $random(seed) & 3;
      rst;
      meas;
      repeat (2)
      begin
        meas;
        check("capture", t3_capture * per <= c + per &&
          t3_capture * per + per >= c, 1);
        check("single", f, 1);
      end
    end
    {t3_cmp1_single, t3_cmp2_single, t3_cmp2_toggle} <= 3'h1;
    {t3_compare1, t3_compare2, t3_int_tick} <= 17'h0_40d;
    {t3_mode, t2_out_mode} <= {`TSC_T3_BURST_T2, `TSC_T2O_TOGGLE_B};
    {t2_clk_sel, t2_narrow, t2_compare} <= 14'h2003;
    for (int p = 0; p < 2; p++)
    begin
      {t3_clk_sel, pin_en} <= {p[0], p[0]};
      rst;
      hi = 0;
      gt = 0;
      t3_rearm <= 1;
      cyc(1);
      t3_rearm <= 0;
      repeat (800)
      begin
        @(negedge ref_clk);
        hi += timer3_output_pin;
        gt += timer3_output_flop && !timer3_output_pin;
      end
      check("burst", {hi != 0, gt != 0}, 3);
    end
    {t3_mode, t2_out_mode} <= {`TSC_T3_BURST_SR, `TSC_T2O_TOGGLE_A};
    {t2_clk_sel, t2_compare, serial_mode, pin_en} <= 16'h0303;
    for (int s = 0; s < 2; s++)
    begin
      shift_src <= s ? `TSC_SH_EXT : `TSC_SH_TIMER2_MATCH_TOGGLE;
      rst;
      d = $random(seed);
      ev(s);
      @(posedge ref_clk);
      {shifter_load, shifter_load_data} <= {1'b1, d};
      cyc(1);
      shifter_load <= 0;
      cyc(4);
      @(negedge ref_clk);
      check("shift", shifter_data_out, d[7]);
      for (int i = 1; i < 9; i++)
      begin
        ev(s);
        check("shift", shifter_data_out, i < 8 ? d[7-i] : 0);
      end
    end
    {t3_mode, t2_out_mode} <= {`TSC_T3_FSK, `TSC_T2O_PRESCALE};
    {t2_prescale, shift_src, t3_cmp2_toggle} <= 7'h7b;
    {t3_compare1, t3_compare2} <= 16'h0307;
    // Interval counts assume one Timer 3 tick per cycle
    t3_clk_sel <= `TSC_CLK_INTERNAL;
    rst;
    shifter_load <= 1;
    shifter_load_data <= $random(seed);
    cyc(1);
    shifter_load <= 0;
    {fl, sd, chg, c} = 0;
    chg = 1;
    repeat (300)
    begin
      @(negedge ref_clk);
      c++;
      chg |= shifter_data_out !== sd;
      sd = shifter_data_out;
      if (timer3_output_flop !== fl)
      begin
        if (!chg)
          check("fsk", c, sd ? t3_compare2 : t3_compare1);
        {c, chg} = 0;
        fl = timer3_output_flop;
      end
    end
    complete_run;
  end
endmodule
